// ==== hw/rsts_map.svh ====
// Offsets-free constant map: encodings, counts and times for the sequencer
`ifndef RSTS_MAP_SVH
`define RSTS_MAP_SVH

// Brown-out enable field encodings
`define RSTS_BEN_OFF        2'h0
`define RSTS_BEN_SOFT       2'h1
`define RSTS_BEN_NO_SLEEP   2'h2
`define RSTS_BEN_ALWAYS     2'h3

// Timer terminal counts (2048 slow ticks, 1024 primary ticks)
`define RSTS_POWER_UP_TIMER_LAST      11'h7ff
`define RSTS_OST_LAST       10'h3ff

// Times in ns and the clock period
`define RSTS_CLK_PERIOD_NS  4
`define RSTS_PLL_LOCK_NS    2000000
`define RSTS_BOR_FILTER_NS  200

// Least times round up to whole cycles
`define RSTS_PLL_LOCK_CYC \
	((`RSTS_PLL_LOCK_NS + `RSTS_CLK_PERIOD_NS - 1) / `RSTS_CLK_PERIOD_NS)
`define RSTS_BOR_FILTER_CYC \
	((`RSTS_BOR_FILTER_NS + `RSTS_CLK_PERIOD_NS - 1) / `RSTS_CLK_PERIOD_NS)

`endif

// ==== hw/rsts_pkg.sv ====
// Types shared by the reset sequencer files
package rsts_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		S_POR  = 3'h0,
		S_BOR  = 3'h1,
		S_POWER_UP_TIMER = 3'h2,
		S_OST  = 3'h3,
		S_PLL  = 3'h4,
		S_RUN  = 3'h5
	} rsts_state_t;

	// Primary oscillator configuration
	typedef enum logic [2:0] {
		OSC_LOW_POWER_CRYSTAL = 3'h0,
		OSC_CRYSTAL           = 3'h1,
		OSC_FAST_CRYSTAL      = 3'h2,
		OSC_FAST_CRYSTAL_PLL  = 3'h3,
		OSC_EXTERNAL_CLOCK    = 3'h4,
		OSC_RES_CAP           = 3'h5,
		OSC_INTERNAL          = 3'h6
	} rsts_osc_mode_t;

	// Configuration word fields
	typedef struct packed {
		logic [1:0]     brownout_enable_field;
		logic [1:0]     brownout_threshold_select;
		logic           power_up_timer_disable_n;
		logic           external_reset_pin_enable;
		rsts_osc_mode_t osc_mode;
	} rsts_cfg_t;

	// Software writes to the reset control register
	typedef struct packed {
		logic por_flag_set;
		logic bor_flag_set;
		logic soft_bor_we;
		logic soft_bor_wdata;
	} rsts_sw_t;

endpackage

// ==== hw/rsts_seq.sv ====
// Power-on and brown-out reset sequencer with start-up timers
`timescale 1ns/1ns
`include "rsts_map.svh"
module rsts_seq
	import rsts_pkg::*;
#(
	parameter int PLL_LOCK_CYCLES   = `RSTS_PLL_LOCK_CYC,
	parameter int BOR_FILTER_CYCLES = `RSTS_BOR_FILTER_CYC
)
(
	input  wire logic       MCLK,
	input  wire logic       RST_B,
	input  wire logic       POR_PULSE,
	input  wire logic       SUPPLY_BELOW_THRESHOLD,
	input  wire logic       REFERENCE_STABLE_FLAG,
	input  wire logic       EXTERNAL_RESET_PIN_N,
	input  wire rsts_cfg_t  CFG,
	input  wire logic       SLEEP_MODE,
	input  wire logic       OSC_STOP_WAKE,
	input  wire logic       SLOW_INTERNAL_OSC,
	input  wire logic       PRIMARY_OSC_INPUT,
	input  wire rsts_sw_t   SW,
	output logic            CORE_RESET,
	output logic            CLOCK_HOLD,
	output logic            POWER_ON_FLAG,
	output logic            BROWNOUT_FLAG,
	output logic            SOFT_BROWNOUT_ENABLE,
	output logic            FIXED_VOLTAGE_REF_REQ,
	output logic [1:0]      BROWNOUT_THRESHOLD,
	output logic            PIN_DIGITAL_IN,
	output rsts_state_t     SEQ_STATE
);
	// Crystal-type modes need the start-up timer
	function automatic logic is_crystal(input rsts_osc_mode_t m);
		is_crystal = (m == OSC_LOW_POWER_CRYSTAL) || (m == OSC_CRYSTAL) ||
			(m == OSC_FAST_CRYSTAL) || (m == OSC_FAST_CRYSTAL_PLL);
	endfunction

	rsts_state_t state_r;
	rsts_state_t state_nxt;
	logic [10:0] power_up_timer_cnt_r;
	logic [9:0]  ost_cnt_r;
	logic [19:0] pll_cnt_r;
	logic [15:0] filt_cnt_r;
	logic        from_por_r;
	logic        wake_r;
	logic        por_flag_r;
	logic        bor_flag_r;
	logic        soft_bor_r;
	logic        armed_r;
	logic        bor_active_r;
	logic        core_reset_r;
	logic        clock_hold_r;
	logic        pin_in_r;
	logic [1:0]  thr_r;
	logic        ref_req_r;

	wire logic slow_tick;
	wire logic prim_tick;

	// Slow and primary oscillator edges brought into MCLK
	rsts_tick_sync u_slow_sync
	(
		.clk    (MCLK),
		.rst_b  (RST_B),
		.osc_in (SLOW_INTERNAL_OSC),
		.tick   (slow_tick)
	);

	rsts_tick_sync u_prim_sync
	(
		.clk    (MCLK),
		.rst_b  (RST_B),
		.osc_in (PRIMARY_OSC_INPUT),
		.tick   (prim_tick)
	);

	// Detection enable from the configuration field
	wire logic soft_mode = CFG.brownout_enable_field == `RSTS_BEN_SOFT;
	wire logic soft_eff  = soft_mode & soft_bor_r;
	wire logic det_en =
		(CFG.brownout_enable_field == `RSTS_BEN_ALWAYS) |
		soft_eff |
		((CFG.brownout_enable_field == `RSTS_BEN_NO_SLEEP) &
		 ~SLEEP_MODE);

	// Brown-out sensing: armed only once the reference is stable
	wire logic sensing  = armed_r & det_en & SUPPLY_BELOW_THRESHOLD;
	wire logic bor_trip = sensing &
		(filt_cnt_r == 16'(BOR_FILTER_CYCLES - 1));
	wire logic bor_hold = bor_trip | (bor_active_r & SUPPLY_BELOW_THRESHOLD);

	// Time-out selection
	wire logic crystal  = is_crystal(CFG.osc_mode);
	wire logic pll_mode = CFG.osc_mode == OSC_FAST_CRYSTAL_PLL;
	wire logic power_up_timer_on  = ~CFG.power_up_timer_disable_n;
	wire logic power_up_timer_done = slow_tick & (power_up_timer_cnt_r == `RSTS_POWER_UP_TIMER_LAST);
	wire logic ost_done  = prim_tick & (ost_cnt_r == `RSTS_OST_LAST);
	wire logic pll_done  = pll_cnt_r == 20'(PLL_LOCK_CYCLES - 1);
	wire logic ost_wanted = crystal & from_por_r;
	wire logic pin_reset =
		CFG.external_reset_pin_enable & ~EXTERNAL_RESET_PIN_N;
	wire logic new_reset = POR_PULSE | bor_hold;

	// Wake from RUN into the start-up timer keeps the core out of reset
	wire logic wake_start = (state_r == S_RUN) & (state_nxt == S_OST);

	// Next state of the time-out sequence
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			S_POR, S_BOR:
			begin
				if (power_up_timer_on)
					state_nxt = S_POWER_UP_TIMER;
				else if (ost_wanted)
					state_nxt = S_OST;
				else
					state_nxt = S_RUN;
			end
			S_POWER_UP_TIMER:
			begin
				if (power_up_timer_done)
					state_nxt = ost_wanted ? S_OST : S_RUN;
			end
			S_OST:
			begin
				if (ost_done)
					state_nxt = pll_mode ? S_PLL : S_RUN;
			end
			S_PLL:
			begin
				if (pll_done)
					state_nxt = S_RUN;
			end
			S_RUN:
			begin
				if (OSC_STOP_WAKE & crystal)
					state_nxt = S_OST;
			end
			default:
				state_nxt = S_POR;
		endcase
		if (POR_PULSE)
			state_nxt = S_POR;
		else if (bor_hold)
			state_nxt = S_BOR;
	end

	// Sequencer state and wake marker
	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_r    <= S_POR;
			from_por_r <= 1'b1;
			wake_r     <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (POR_PULSE)
				from_por_r <= 1'b1;
			else if (bor_hold)
				from_por_r <= 1'b0;
			if (new_reset)
				wake_r <= 1'b0;
			else if (wake_start)
				wake_r <= 1'b1;
			else if (state_nxt == S_RUN)
				wake_r <= 1'b0;
		end
	end

	// Timer counters, cleared whenever their state is not running
	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			power_up_timer_cnt_r <= 11'h000;
			ost_cnt_r  <= 10'h000;
			pll_cnt_r  <= 20'h0_0000;
		end
		else
		begin
			if (new_reset || state_r != S_POWER_UP_TIMER)
				power_up_timer_cnt_r <= 11'h000;
			else if (slow_tick)
				power_up_timer_cnt_r <= power_up_timer_cnt_r + 11'h001;
			if (new_reset || state_r != S_OST)
				ost_cnt_r <= 10'h000;
			else if (prim_tick)
				ost_cnt_r <= ost_cnt_r + 10'h001;
			if (new_reset || state_r != S_PLL)
				pll_cnt_r <= 20'h0_0000;
			else
				pll_cnt_r <= pll_cnt_r + 20'h0_0001;
		end
	end

	// Brown-out arming, filter and hold
	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			armed_r      <= 1'b0;
			filt_cnt_r   <= 16'h0000;
			bor_active_r <= 1'b0;
		end
		else
		begin
			if (!det_en)
				armed_r <= 1'b0;
			else if (REFERENCE_STABLE_FLAG)
				armed_r <= 1'b1;
			if (!sensing || bor_trip)
				filt_cnt_r <= 16'h0000;
			else
				filt_cnt_r <= filt_cnt_r + 16'h0001;
			bor_active_r <= bor_hold;
		end
	end

	// Status flags; hardware clear wins over a software set
	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			por_flag_r <= 1'b0;
			bor_flag_r <= 1'b0;
			soft_bor_r <= 1'b0;
		end
		else
		begin
			if (POR_PULSE)
				por_flag_r <= 1'b0;
			else if (SW.por_flag_set)
				por_flag_r <= 1'b1;
			if (POR_PULSE || bor_trip)
				bor_flag_r <= 1'b0;
			else if (SW.bor_flag_set)
				bor_flag_r <= 1'b1;
			if (POR_PULSE)
				soft_bor_r <= soft_mode;
			else if (SW.soft_bor_we && soft_mode)
				soft_bor_r <= SW.soft_bor_wdata;
		end
	end

	// Registered outputs
	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			core_reset_r <= 1'b1;
			clock_hold_r <= 1'b1;
			pin_in_r     <= 1'b0;
			thr_r        <= 2'h0;
			ref_req_r    <= 1'b0;
		end
		else
		begin
			core_reset_r <= ((state_nxt != S_RUN) & ~wake_r & ~wake_start) |
				new_reset | pin_reset;
			clock_hold_r <= state_nxt != S_RUN;
			pin_in_r     <= CFG.external_reset_pin_enable ? 1'b0 :
				EXTERNAL_RESET_PIN_N;
			thr_r        <= CFG.brownout_threshold_select;
			ref_req_r    <= det_en;
		end
	end

	assign CORE_RESET            = core_reset_r;
	assign CLOCK_HOLD            = clock_hold_r;
	assign POWER_ON_FLAG         = por_flag_r;
	assign BROWNOUT_FLAG         = bor_flag_r;
	assign SOFT_BROWNOUT_ENABLE  = soft_bor_r & soft_mode;
	assign FIXED_VOLTAGE_REF_REQ = ref_req_r;
	assign BROWNOUT_THRESHOLD    = thr_r;
	assign PIN_DIGITAL_IN        = pin_in_r;
	assign SEQ_STATE             = state_r;
endmodule

// ==== hw/rsts_tick_sync.sv ====
// Oscillator edge synchroniser giving one-cycle ticks in the sequencer clock
`timescale 1ns/1ns
module rsts_tick_sync
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic osc_in,
	output logic      tick
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// Two-flop synchroniser, then a delay stage for edge detection
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// All high: a high input at release is not taken as an edge
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end
		else
		begin
			meta_r <= osc_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// Rising edge seen only past the synchroniser
	assign tick = sync_r & ~prev_r;
endmodule

// ==== verif/rsts_seq_checker.sv ====
// Port assertions for the reset sequencer
`timescale 1ns/1ns
module rsts_seq_checker
	import rsts_pkg::*;
#(
	parameter int BOR_FILTER_CYCLES = 50
)
(
	input wire logic        MCLK,
	input wire logic        RST_B,
	input wire logic        POR_PULSE,
	input wire logic        SUPPLY_BELOW_THRESHOLD,
	input wire logic        EXTERNAL_RESET_PIN_N,
	input wire rsts_cfg_t   CFG,
	input wire logic        SLEEP_MODE,
	input wire logic        CORE_RESET,
	input wire logic        POWER_ON_FLAG,
	input wire logic        BROWNOUT_FLAG,
	input wire logic        SOFT_BROWNOUT_ENABLE,
	input wire logic        FIXED_VOLTAGE_REF_REQ,
	input wire rsts_state_t SEQ_STATE
);
	logic [7:0] below_cnt_r;
	logic [7:0] below_cnt_nxt;

	// Consecutive cycles below the threshold, saturating
	assign below_cnt_nxt = !SUPPLY_BELOW_THRESHOLD ? 8'h00 :
		below_cnt_r + {7'h00, below_cnt_r != 8'hff};
	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
			below_cnt_r <= 8'h00;
		else
			below_cnt_r <= below_cnt_nxt;
	end

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);

	// Flags, software bit and reference request
	chk_por_clears: assert property (POR_PULSE |=> !POWER_ON_FLAG)
		else $error("power-on flag kept");
	chk_soft_zero: assert property ((CFG.brownout_enable_field != 2'h1)
		|-> !SOFT_BROWNOUT_ENABLE) else $error("soft bit outside mode");
	chk_bor_flag: assert property ($rose(SEQ_STATE == S_BOR)
		|-> !BROWNOUT_FLAG) else $error("brown-out flag kept");
	chk_ref_off: assert property ((CFG.brownout_enable_field == 2'h0 ||
		(CFG.brownout_enable_field == 2'h2 && SLEEP_MODE))
		|=> !FIXED_VOLTAGE_REF_REQ) else $error("reference kept on");

	// Brown-out entry, hold and filter
	chk_bor_hold: assert property ((SEQ_STATE == S_BOR &&
		SUPPLY_BELOW_THRESHOLD && !POR_PULSE)
		|=> SEQ_STATE == S_BOR && CORE_RESET) else $error("left brown-out");
	chk_bor_filter: assert property ($rose(SEQ_STATE == S_BOR)
		|-> below_cnt_r >= BOR_FILTER_CYCLES) else $error("dip too short");
	chk_off_no_bor: assert property ((CFG.brownout_enable_field == 2'h0 &&
		SEQ_STATE != S_BOR) |=> SEQ_STATE != S_BOR) else $error("sensed when off");

	// Core reset in the power-up timer or while the pin is held
	chk_power_up_timer_reset: assert property (SEQ_STATE == S_POWER_UP_TIMER |-> CORE_RESET)
		else $error("timer without reset");
	chk_pin_reset: assert property ((CFG.external_reset_pin_enable &&
		!EXTERNAL_RESET_PIN_N) |=> CORE_RESET) else $error("pin ignored");

	// Main scenarios reached
	cov_bor: cover property ($rose(SEQ_STATE == S_BOR));
	cov_wake: cover property (SEQ_STATE == S_OST && !CORE_RESET);
	cov_pll: cover property (SEQ_STATE == S_PLL);
endmodule

bind rsts_seq rsts_seq_checker #(.BOR_FILTER_CYCLES(BOR_FILTER_CYCLES))
	u_rsts_seq_checker (
	.MCLK(MCLK), .RST_B(RST_B), .POR_PULSE(POR_PULSE),
	.SUPPLY_BELOW_THRESHOLD(SUPPLY_BELOW_THRESHOLD),
	.EXTERNAL_RESET_PIN_N(EXTERNAL_RESET_PIN_N), .CFG(CFG),
	.SLEEP_MODE(SLEEP_MODE), .CORE_RESET(CORE_RESET),
	.POWER_ON_FLAG(POWER_ON_FLAG), .BROWNOUT_FLAG(BROWNOUT_FLAG),
	.SOFT_BROWNOUT_ENABLE(SOFT_BROWNOUT_ENABLE),
	.FIXED_VOLTAGE_REF_REQ(FIXED_VOLTAGE_REF_REQ), .SEQ_STATE(SEQ_STATE));

// ==== verif/rsts_supply_model.sv ====
// Oscillator and reference models facing the reset sequencer
`timescale 1ns/1ns
module rsts_supply_model
(
	input  wire logic clk,
	input  wire logic ref_req,
	output logic      slow_osc,
	output logic      prim_osc,
	output logic      ref_stable
);
	logic [2:0] slow_cnt_r = 3'h0;
	logic [1:0] prim_cnt_r = 2'h0;
	logic [2:0] settle_r   = 3'h0;

	// Free-running oscillators, six and four clock periods long
	always_ff @(posedge clk)
	begin
		slow_cnt_r <= (slow_cnt_r == 3'h5) ? 3'h0 : slow_cnt_r + 3'h1;
		prim_cnt_r <= prim_cnt_r + 2'h1;
		settle_r   <= !ref_req ? 3'h0 : settle_r + {2'h0, settle_r != 3'h7};
	end

	// Reference settles seven cycles after it is requested
	assign slow_osc   = (slow_cnt_r < 3'h3);
	assign prim_osc   = prim_cnt_r[1];
	assign ref_stable = (settle_r == 3'h7);
endmodule

// ==== verif/tb_rsts_seq.sv ====
// Self-checking bench for the reset sequencer
`timescale 1ns/1ns
module tb_rsts_seq
	import rsts_pkg::*;
;
	logic        mclk, rst_b, por, below, pin_n, sleep, wake;
	logic        core_rst, hold, pof, bof, soft_en, ref_req, pin_in;
	logic        slow, prim, ref_ok;
	logic [1:0]  thr;
	rsts_cfg_t   cfg;
	rsts_sw_t    sw;
	rsts_state_t st;
	int          n_errors = 0;
	int          samples_checked = 0;

	// Sequencer with short lock and filter counts, and its far side
	rsts_seq #(.PLL_LOCK_CYCLES(20), .BOR_FILTER_CYCLES(4)) u_rsts_seq (
		.MCLK(mclk), .RST_B(rst_b), .POR_PULSE(por),
		.SUPPLY_BELOW_THRESHOLD(below), .REFERENCE_STABLE_FLAG(ref_ok),
		.EXTERNAL_RESET_PIN_N(pin_n), .CFG(cfg), .SLEEP_MODE(sleep),
		.OSC_STOP_WAKE(wake), .SLOW_INTERNAL_OSC(slow),
		.PRIMARY_OSC_INPUT(prim), .SW(sw), .CORE_RESET(core_rst),
		.CLOCK_HOLD(hold), .POWER_ON_FLAG(pof), .BROWNOUT_FLAG(bof),
		.SOFT_BROWNOUT_ENABLE(soft_en), .FIXED_VOLTAGE_REF_REQ(ref_req),
		.BROWNOUT_THRESHOLD(thr), .PIN_DIGITAL_IN(pin_in), .SEQ_STATE(st));
	rsts_supply_model u_rsts_supply_model (.clk(mclk), .ref_req(ref_req),
		.slow_osc(slow), .prim_osc(prim), .ref_stable(ref_ok));

	// Comparison, waits and supply steps
	task automatic check(input logic [15:0] seen, exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s exp %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge mclk);
	endtask
	task automatic dip(input logic v, input int k);
		@(posedge mclk);
		below <= v;
		cyc(k);
	endtask
	task automatic wait_for(input rsts_state_t s, output int n);
		n = 0;
		while (st !== s && n < 20000)
		begin
			@(negedge mclk);
			n++;
		end
		check(st, s, "reach");
	endtask
	task automatic report_and_stop;
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Power-up through every timer with the pin held low
	task automatic t_power_up;
		int n;
		@(posedge mclk);
		por <= 1'b0;
		wait_for(S_POWER_UP_TIMER, n);
		check(pof, 1'b0, "pof");
		wait_for(S_OST, n);
		check(n > 12280 && n < 12296, 1'b1, "power_up_timer");
		wait_for(S_PLL, n);
		check(n > 4088 && n < 4102, 1'b1, "ost");
		wait_for(S_RUN, n);
		check(n > 17 && n < 23, 1'b1, "pll");
		check({core_rst, bof, thr}, 4'ha, "pin");
		@(posedge mclk);
		pin_n <= 1'b1;
		cyc(2);
		check(core_rst, 1'b0, "release");
	endtask

	// Software flag sets, then brown-outs from run and inside the power-up timer
	task automatic t_brownout;
		int n;
		@(posedge mclk);
		sw <= 4'hc;
		@(posedge mclk);
		sw <= 4'h0;
		cyc(1);
		check({pof, bof}, 2'h3, "set");
		dip(1'b1, 40);
		check({st, core_rst, pof, bof}, {S_BOR, 3'h6}, "bor");
		dip(1'b0, 100);
		check(st, S_POWER_UP_TIMER, "power_up_timer");
		dip(1'b1, 10);
		check(st, S_BOR, "again");
		dip(1'b0, 0);
		wait_for(S_POWER_UP_TIMER, n);
		wait_for(S_RUN, n);
		check(n > 12280 && n < 12296, 1'b1, "restart");
	endtask

	// Sensing under each enable setting, power-up timer skipped
	task automatic t_modes;
		logic [3:0] tbl [6] = '{4'h0, 4'h4, 4'h6, 4'h9, 4'h8, 4'hd};
		logic       on;
		@(posedge mclk);
		cfg.power_up_timer_disable_n <= 1'b1;
		dip(1'b1, 2);
		dip(1'b0, 8);
		check(st, S_RUN, "short");
		foreach (tbl[i])
		begin
			@(posedge mclk);
			cfg.brownout_enable_field <= tbl[i][3:2];
			sleep <= tbl[i][0];
			sw <= {3'h1, tbl[i][1]};
			@(posedge mclk);
			sw <= 4'h0;
			cyc(12);
			on = tbl[i][3:2] == 2'h3 || (tbl[i][3:2] == 2'h2 && !tbl[i][0])
				|| (tbl[i][3:2] == 2'h1 && tbl[i][1]);
			check({soft_en, ref_req}, {tbl[i][3:1] == 3'h3, on}, "en");
			dip(1'b1, 20);
			check(st == S_BOR, on, "trip");
			dip(1'b0, 4);
			check(st, S_RUN, "run");
		end
	endtask

	// Oscillator-stop wake, then power-on in resistor-capacitor mode
	task automatic t_wake;
		int n;
		@(posedge mclk);
		wake <= 1'b1;
		@(posedge mclk);
		wake <= 1'b0;
		cyc(2);
		check({st, core_rst, hold}, {S_OST, 2'h1}, "wake");
		wait_for(S_RUN, n);
		check(n > 4100 && n < 4126, 1'b1, "lock");
		@(posedge mclk);
		cfg.osc_mode <= OSC_RES_CAP;
		por <= 1'b1;
		cyc(3);
		check(pof, 1'b0, "por");
		@(posedge mclk);
		por <= 1'b0;
		cyc(3);
		check({st, core_rst}, {S_RUN, 1'b0}, "rc");
		@(posedge mclk);
		wake <= 1'b1;
		@(posedge mclk);
		wake <= 1'b0;
		cyc(2);
		check(st, S_RUN, "refused");
		@(posedge mclk);
		cfg.osc_mode <= OSC_CRYSTAL;
		wake <= 1'b1;
		@(posedge mclk);
		wake <= 1'b0;
		cyc(1);
		wait_for(S_RUN, n);
		check(n > 4085 && n < 4100, 1'b1, "no pll");
	endtask

	// Pin reset disabled: the pin reads as a plain input
	task automatic t_pin;
		@(posedge mclk);
		cfg.external_reset_pin_enable <= 1'b0;
		pin_n <= 1'b0;
		cyc(3);
		check({core_rst, pin_in}, 2'h0, "low");
		@(posedge mclk);
		pin_n <= 1'b1;
		cyc(3);
		check({core_rst, pin_in}, 2'h1, "high");
	endtask

	// Clock
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Reset with the power-on pulse high, then the scenarios
	initial
	begin
		rst_b = 1'b0;
		por = 1'b1;
		below = 1'b0;
		pin_n = 1'b0;
		sleep = 1'b0;
		wake = 1'b0;
		sw = 4'h0;
		cfg = '{2'h3, 2'h2, 1'b0, 1'b1, OSC_FAST_CRYSTAL_PLL};
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		t_power_up();
		t_brownout();
		t_modes();
		t_wake();
		t_pin();
		report_and_stop();
	end

	// Watchdog at nearly three times the expected run length
	initial
	begin
		#400000;
		n_errors++;
		report_and_stop();
	end
endmodule
